// File: src/cdu_pkg.sv
// Package for the current DAC update scheduler: register addresses, field layout and reset values.
// Assumes an 8-bit special-function register space with byte addresses.
package cdu_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 12;
  localparam int ADDR_W = 8;
  // Register addresses in the special-function space.
  localparam logic [ADDR_W-1:0] ADDR_DAC0_CONTROL = 8'hb9;
  localparam logic [ADDR_W-1:0] ADDR_DAC1_CONTROL = 8'hb5;
  localparam logic [ADDR_W-1:0] ADDR_DAC0_DATA_HIGH = 8'h97;
  localparam logic [ADDR_W-1:0] ADDR_DAC0_DATA_LOW = 8'h96;
  localparam logic [ADDR_W-1:0] ADDR_DAC1_DATA_HIGH = 8'hf5;
  localparam logic [ADDR_W-1:0] ADDR_DAC1_DATA_LOW = 8'hf4;
  // Control register field positions.
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_SRC_HI = 6;
  localparam int CTL_SRC_LO = 4;
  localparam int CTL_RSVD_BIT = 3;
  localparam int CTL_RJST_BIT = 2;
  localparam int CTL_FS_HI = 1;
  localparam int CTL_FS_LO = 0;
  // Reset values and control write mask.
  localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h73;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CONTROL_WMASK = 8'hf7;
  // Update source encodings.
  localparam logic [2:0] SRC_TIMER0 = 3'h0;
  localparam logic [2:0] SRC_TIMER1 = 3'h1;
  localparam logic [2:0] SRC_TIMER2 = 3'h2;
  localparam logic [2:0] SRC_TIMER3 = 3'h3;
  localparam logic [2:0] SRC_RISE = 3'h4;
  localparam logic [2:0] SRC_FALL = 3'h5;
  localparam logic [2:0] SRC_ANY = 3'h6;
  localparam logic [2:0] SRC_WRITE = 3'h7;
  // Full-scale range encodings.
  localparam logic [1:0] FS_0P25MA = 2'h0;
  localparam logic [1:0] FS_0P5MA = 2'h1;
  localparam logic [1:0] FS_1MA = 2'h2;
  localparam logic [1:0] FS_2MA = 2'h3;
endpackage : cdu_pkg

// File: src/cdu_channel.sv
// One DAC channel: control register, held data bytes, trigger selection and input latch.
// Assumes single-cycle register writes and trigger pulses already on the system clock.
`timescale 1ns/100ps
module cdu_channel
  import cdu_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ctl_we, // Write strobe for the control register.
  input wire logic low_we, // Write strobe for the data low byte.
  input wire logic high_we, // Write strobe for the data high byte.
  input wire logic [DATA_W-1:0] wdata, // Write data.
  input wire logic [3:0] timer_ovf, // Timer overflow pulses, already mode-selected.
  input wire logic cnv_rise, // Rising edge pulse of conversion start.
  input wire logic cnv_fall, // Falling edge pulse of conversion start.
  output logic [DATA_W-1:0] control, // Control register read value.
  output logic [DATA_W-1:0] data_low, // Held low byte.
  output logic [DATA_W-1:0] data_high, // Held high byte.
  output logic [WORD_W-1:0] dac_word, // Input latch to the analog core.
  output logic enable, // Channel enable.
  output logic [1:0] full_scale, // Full-scale range code.
  output logic update // Pulse when the input latch loads.
);
  logic [DATA_W-1:0] ctl_r, ctl_nxt;
  logic [DATA_W-1:0] low_r, low_nxt;
  logic [DATA_W-1:0] high_r, high_nxt;
  logic [WORD_W-1:0] latch_r, latch_nxt;
  logic upd_r, upd_nxt;
  logic [2:0] src;
  logic trig;
  logic [WORD_W-1:0] word_from;

  // Next-state logic for registers, trigger and latch.
  always_comb begin
    ctl_nxt = ctl_r;
    low_nxt = low_r;
    high_nxt = high_r;
    src = ctl_r[CTL_SRC_HI:CTL_SRC_LO];
    if (ctl_we) begin
      ctl_nxt = wdata & CONTROL_WMASK;
    end
    if (low_we) begin
      low_nxt = wdata;
    end
    if (high_we) begin
      high_nxt = wdata;
    end
    // Trigger selection; the source in force before this cycle's control write applies.
    case (src)
      SRC_TIMER0: trig = timer_ovf[0];
      SRC_TIMER1: trig = timer_ovf[1];
      SRC_TIMER2: trig = timer_ovf[2];
      SRC_TIMER3: trig = timer_ovf[3];
      SRC_RISE: trig = cnv_rise;
      SRC_FALL: trig = cnv_fall;
      SRC_ANY: trig = cnv_rise | cnv_fall;
      default: trig = high_we;
    endcase
    // Justify the held bytes, including any byte written this very cycle.
    if (ctl_r[CTL_RJST_BIT]) begin
      word_from = {high_nxt[3:0], low_nxt};
    end else begin
      word_from = {high_nxt, low_nxt[7:4]};
    end
    latch_nxt = trig ? word_from : latch_r;
    upd_nxt = trig;
  end

  // Register stage.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= CONTROL_RESET;
      low_r <= DATA_RESET;
      high_r <= DATA_RESET;
      latch_r <= '0;
      upd_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      low_r <= low_nxt;
      high_r <= high_nxt;
      latch_r <= latch_nxt;
      upd_r <= upd_nxt;
    end
  end

  // Outputs.
  assign control = ctl_r;
  assign data_low = low_r;
  assign data_high = high_r;
  assign dac_word = latch_r;
  assign enable = ctl_r[CTL_ENABLE_BIT];
  assign full_scale = ctl_r[CTL_FS_HI:CTL_FS_LO];
  assign update = upd_r;
endmodule : cdu_channel

// File: src/cdu_scheduler.sv
// Top of the two-channel current DAC update scheduler on the CPU register space.
// Assumes timer overflow pulses on the system clock and an asynchronous conversion-start pin.
`timescale 1ns/100ps
module cdu_scheduler
  import cdu_pkg::*;
(
  input wire logic clock, // System clock, 100 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [ADDR_W-1:0] sfr_addr, // Register address.
  input wire logic [DATA_W-1:0] sfr_wdata, // Register write data.
  input wire logic sfr_we, // Write strobe, one cycle.
  input wire logic sfr_re, // Read strobe, one cycle.
  output logic [DATA_W-1:0] sfr_rdata, // Read data, registered.
  output logic sfr_hit, // Address maps to this block.
  input wire logic [1:0] timer_low_ovf, // Low-byte overflow pulses of timers 2 and 3.
  input wire logic [1:0] timer_high_ovf, // High-byte overflow pulses of timers 2 and 3.
  input wire logic [1:0] timer_split8, // Timers 2 and 3 run in 8-bit mode.
  input wire logic [1:0] timer01_ovf, // Overflow pulses of timers 0 and 1.
  input wire logic conversion_start_pin, // Asynchronous conversion-start pin.
  input wire logic output_merge_select, // Merge select from the reference control.
  output logic [WORD_W-1:0] current_dac_first_word, // First channel input latch.
  output logic [WORD_W-1:0] current_dac_second_word, // Second channel input latch.
  output logic [1:0] dac_enable, // Per-channel enable.
  output logic [1:0] dac0_full_scale, // First channel range code.
  output logic [1:0] dac1_full_scale, // Second channel range code.
  output logic [1:0] dac_update, // Per-channel latch-load pulse.
  output logic bias_request, // Request to the bias generator.
  output logic merge_active, // Both outputs routed to first pin.
  output logic second_on_own_pin // Second output on its own pin.
);
  logic [1:0] cnv_sync_r, cnv_sync_nxt;
  logic cnv_prev_r, cnv_prev_nxt;
  logic cnv_rise, cnv_fall;
  logic [3:0] timer_ovf;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0] ctl_we, low_we, high_we;
  logic [DATA_W-1:0] ch_ctl [2];
  logic [DATA_W-1:0] ch_low [2];
  logic [DATA_W-1:0] ch_high [2];
  logic [WORD_W-1:0] ch_word [2];
  logic [1:0] ch_fs [2];
  logic hit;

  // Timer 2 and 3 overflow selection by counting mode.
  assign timer_ovf[1:0] = timer01_ovf;
  assign timer_ovf[2] = timer_split8[0] ? timer_low_ovf[0] : timer_high_ovf[0];
  assign timer_ovf[3] = timer_split8[1] ? timer_low_ovf[1] : timer_high_ovf[1];

  // Pin synchroniser and edge detector; only the second stage is observed.
  always_comb begin
    cnv_sync_nxt = {cnv_sync_r[0], conversion_start_pin};
    cnv_prev_nxt = cnv_sync_r[1];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnv_sync_r <= 2'b00;
      cnv_prev_r <= 1'b0;
    end else begin
      cnv_sync_r <= cnv_sync_nxt;
      cnv_prev_r <= cnv_prev_nxt;
    end
  end

  assign cnv_rise = cnv_sync_r[1] & ~cnv_prev_r;
  assign cnv_fall = ~cnv_sync_r[1] & cnv_prev_r;

  // Address decode of write strobes.
  always_comb begin
    ctl_we = 2'b00;
    low_we = 2'b00;
    high_we = 2'b00;
    hit = 1'b1;
    if (sfr_addr == ADDR_DAC0_CONTROL) begin
      ctl_we[0] = sfr_we;
    end else if (sfr_addr == ADDR_DAC1_CONTROL) begin
      ctl_we[1] = sfr_we;
    end else if (sfr_addr == ADDR_DAC0_DATA_LOW) begin
      low_we[0] = sfr_we;
    end else if (sfr_addr == ADDR_DAC0_DATA_HIGH) begin
      high_we[0] = sfr_we;
    end else if (sfr_addr == ADDR_DAC1_DATA_LOW) begin
      low_we[1] = sfr_we;
    end else if (sfr_addr == ADDR_DAC1_DATA_HIGH) begin
      high_we[1] = sfr_we;
    end else begin
      hit = 1'b0;
    end
  end

  assign sfr_hit = hit;

  // Two identical channels, each with its own control register.
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    cdu_channel u_channel (
      .clock(clock),
      .rst_n(rst_n),
      .ctl_we(ctl_we[ch]),
      .low_we(low_we[ch]),
      .high_we(high_we[ch]),
      .wdata(sfr_wdata),
      .timer_ovf(timer_ovf),
      .cnv_rise(cnv_rise),
      .cnv_fall(cnv_fall),
      .control(ch_ctl[ch]),
      .data_low(ch_low[ch]),
      .data_high(ch_high[ch]),
      .dac_word(ch_word[ch]),
      .enable(dac_enable[ch]),
      .full_scale(ch_fs[ch]),
      .update(dac_update[ch])
    );
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_re) begin
      if (sfr_addr == ADDR_DAC0_CONTROL) begin
        rdata_nxt = ch_ctl[0];
      end else if (sfr_addr == ADDR_DAC1_CONTROL) begin
        rdata_nxt = ch_ctl[1];
      end else if (sfr_addr == ADDR_DAC0_DATA_LOW) begin
        rdata_nxt = ch_low[0];
      end else if (sfr_addr == ADDR_DAC0_DATA_HIGH) begin
        rdata_nxt = ch_high[0];
      end else if (sfr_addr == ADDR_DAC1_DATA_LOW) begin
        rdata_nxt = ch_low[1];
      end else if (sfr_addr == ADDR_DAC1_DATA_HIGH) begin
        rdata_nxt = ch_high[1];
      end else begin
        rdata_nxt = DATA_RESET;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= DATA_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs to the analog core and pin routing.
  assign sfr_rdata = rdata_r;
  assign current_dac_first_word = ch_word[0];
  assign current_dac_second_word = ch_word[1];
  assign dac0_full_scale = ch_fs[0];
  assign dac1_full_scale = ch_fs[1];
  assign bias_request = |dac_enable;
  assign merge_active = (&dac_enable) & output_merge_select;
  assign second_on_own_pin = dac_enable[1] & ~merge_active;
endmodule : cdu_scheduler

// File: tb/cdu_checker.sv
// Port checker for the DAC update scheduler.
// Assumes binding to cdu_scheduler on one clock.
`timescale 1ns/100ps
module cdu_checker
  import cdu_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic [ADDR_W-1:0] sfr_addr, // Address.
  input wire logic [DATA_W-1:0] sfr_wdata, // Write data.
  input wire logic sfr_we, // Write strobe.
  input wire logic sfr_re, // Read strobe.
  input wire logic [DATA_W-1:0] sfr_rdata, // Read data.
  input wire logic sfr_hit, // Mapped.
  input wire logic output_merge_select, // Merge select.
  input wire logic [WORD_W-1:0] current_dac_first_word, // Latch.
  input wire logic [1:0] dac_enable, // Enables.
  input wire logic [1:0] dac0_full_scale, // Range.
  input wire logic [1:0] dac_update, // Loads.
  input wire logic bias_request, // Bias.
  input wire logic merge_active, // Merged.
  input wire logic second_on_own_pin // Own pin.
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A control write to the first channel.
  sequence ctl_wr_s;
    sfr_we && sfr_addr == ADDR_DAC0_CONTROL;
  endsequence
  // Outputs are tied to their causes.
  bias_follow_a: assert property (bias_request == |dac_enable) else $error("bias wrong");
  merge_route_a: assert property (merge_active == (&dac_enable && output_merge_select)) else $error("merge wrong");
  own_pin_a: assert property (second_on_own_pin == (dac_enable[1] && !merge_active)) else $error("pin wrong");
  enable_write_a: assert property (ctl_wr_s |=> dac_enable[0] == $past(sfr_wdata[7])) else $error("enable");
  range_write_a: assert property (ctl_wr_s |=> dac0_full_scale == $past(sfr_wdata[1:0])) else $error("range");
  rsvd_read_a: assert property (sfr_re && sfr_addr == ADDR_DAC0_CONTROL |=> !sfr_rdata[3]) else $error("bit3");
  latch_cause_a: assert property ($changed(current_dac_first_word) |-> dac_update[0]) else $error("load");
  unmapped_read_a: assert property (sfr_re && !sfr_hit |=> sfr_rdata == 8'h00) else $error("unmapped");
endmodule : cdu_checker
bind cdu_scheduler cdu_checker u_cdu_checker (.clock, .rst_n, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re,
  .sfr_rdata, .sfr_hit, .output_merge_select, .current_dac_first_word, .dac_enable, .dac0_full_scale,
  .dac_update, .bias_request, .merge_active, .second_on_own_pin);

// File: tb/cdu_timer_model.sv
// Timer overflow model on the far side of the scheduler.
// Assumes the bench requests each pulse one cycle ahead.
`timescale 1ns/100ps
module cdu_timer_model (
  input wire logic clock, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic [5:0] kick, // Pulse requests.
  output logic [1:0] timer01_ovf, // Timers 0 and 1.
  output logic [1:0] timer_low_ovf, // Low overflows.
  output logic [1:0] timer_high_ovf // High overflows.
);
  logic [5:0] ovf_r;
  // Each request becomes one overflow pulse.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ovf_r <= 6'h00;
    end else begin
      ovf_r <= kick;
    end
  end
  // Pulses fan out to the three groups.
  assign timer01_ovf = ovf_r[1:0];
  assign timer_low_ovf = ovf_r[3:2];
  assign timer_high_ovf = ovf_r[5:4];
endmodule : cdu_timer_model

// File: tb/tb_current_dac_update_scheduler.sv
// Random bench for the DAC update scheduler.
// Assumes the timer model and the bound checker.
`timescale 1ns/100ps
module tb_current_dac_update_scheduler;
  import cdu_pkg::*;
  logic clock = 0, rst_n = 0, sfr_we = 0, sfr_re = 0, pin = 0, output_merge_select = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic [5:0] kick = 0;
  logic [1:0] timer_split8 = 0, timer01_ovf, timer_low_ovf, timer_high_ovf, dac_enable, fs0, fs1, ene = 0;
  logic [11:0] w0, w1, ew [2] = '{12'h000, 12'h000};
  logic sfr_hit, bias_request;
  logic [1:0] dac_update;
  logic [7:0] d8;
  int ucnt [2] = '{0, 0};
  logic [31:0] r = 32'h0000_5545;
  int err_count = 0, checks = 0, cyc = 0;
  localparam logic [7:0] CA [2] = '{ADDR_DAC0_CONTROL, ADDR_DAC1_CONTROL};
  localparam logic [7:0] LA [2] = '{ADDR_DAC0_DATA_LOW, ADDR_DAC1_DATA_LOW};
  localparam logic [7:0] HA [2] = '{ADDR_DAC0_DATA_HIGH, ADDR_DAC1_DATA_HIGH};
  cdu_scheduler u_cdu_scheduler (.clock, .rst_n, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re, .sfr_rdata,
    .sfr_hit, .timer_low_ovf, .timer_high_ovf, .timer_split8, .timer01_ovf, .conversion_start_pin(pin),
    .output_merge_select, .current_dac_first_word(w0), .current_dac_second_word(w1), .dac_enable,
    .dac0_full_scale(fs0), .dac1_full_scale(fs1), .dac_update, .bias_request, .merge_active(),
    .second_on_own_pin());
  cdu_timer_model u_cdu_timer_model (.clock, .rst_n, .kick, .timer01_ovf, .timer_low_ovf, .timer_high_ovf);
  // Clock and hang guard.
  always #5 clock = ~clock;
  // Count latch-load pulses per channel, sampled mid-cycle where they are settled.
  always @(negedge clock) begin
    if (dac_update[0]) ucnt[0]++;
    if (dac_update[1]) ucnt[1]++;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // Helpers for stimulus and comparison.
  function automatic logic [7:0] rnd();
    r = r ^ (r << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r[7:0];
  endfunction : rnd
  function automatic logic [11:0] expw(logic [7:0] h, logic [7:0] l, logic rj);
    return rj ? {h[3:0], l} : {h, l[7:4]};
  endfunction : expw
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_we <= 1'b1;
    @(posedge clock);
    sfr_we <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    sfr_re <= 1'b1;
    @(posedge clock);
    sfr_re <= 1'b0;
    @(negedge clock);
    chk({4'h0, sfr_rdata}, {4'h0, exp});
  endtask : rd
  task automatic cw();
    @(negedge clock);
    chk(w0, ew[0]);
    chk(w1, ew[1]);
  endtask : cw
  // Pin toggle, or a pulse on the chosen or a wrong timer line.
  task automatic fire(logic [2:0] s, logic bad);
    @(posedge clock);
    if (s[2]) pin <= ~pin;
    else if (!s[1]) kick <= 6'h01 << (s[0] ^ bad);
    else kick <= ((timer_split8[s[0]] ^ bad) ? 6'h04 : 6'h10) << s[0];
    @(posedge clock);
    kick <= 6'h00;
    repeat (8) @(posedge clock);
  endtask : fire
  // One channel: configure, write low then high, trigger.
  task automatic upd(logic ch, logic [2:0] s);
    logic [7:0] c;
    logic [7:0] h;
    logic [7:0] l;
    int u;
    h = rnd();
    c = {h[7], s, 1'b0, h[2:0]};
    l = rnd();
    @(posedge clock);
    pin <= (s == 3'h4);
    output_merge_select <= h[6];
    timer_split8 <= h[5:4];
    repeat (8) @(posedge clock);
    wr(CA[ch], c);
    ene[ch] = c[7];
    rd(CA[ch], c & 8'hf7);
    chk({7'h0, bias_request, dac_enable, ch ? fs1 : fs0}, {7'h0, |ene, ene, c[1:0]});
    h = rnd();
    wr(LA[ch], l);
    cw();
    wr(HA[ch], h);
    if (s == 3'h7) ew[ch] = expw(h, l, c[2]);
    cw();
    if (s != 3'h7) begin
      if (s != 3'h6) fire(s, 1'b1);
      cw();
      fire(s, 1'b0);
      ew[ch] = expw(h, l, c[2]);
      cw();
      u = ucnt[ch];
      repeat ((s[2] && !s[1]) ? 2 : 1) fire(s, 1'b0);
      cw();
      chk(12'(ucnt[ch] - u), 12'h001);
    end
  endtask : upd
  task automatic final_report();
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // Reset, reset values, then every source on both channels.
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(CA[0], CONTROL_RESET);
    rd(CA[1], CONTROL_RESET);
    rd(8'h00, 8'h00);
    rd(LA[1], DATA_RESET);
    chk({7'h0, bias_request, dac_enable, fs1}, 12'h003);
    // Eight-bit use: preload the low byte with zero once, then only high-byte writes.
    wr(LA[0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      d8 = rnd();
      wr(HA[0], d8);
      ew[0] = {d8, 4'h0};
      cw();
    end
    for (int i = 0; i < 32; i++) upd(i[0], i[3:1]);
    final_report();
  end
endmodule : tb_current_dac_update_scheduler
